// ==== hw/pcrc_pkg.sv ====
package pcrc_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses on the bus.
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_CONTROL = 5'h00;
  localparam logic [4:0] OFF_WIDTH_CFG = 5'h04;
  localparam logic [4:0] OFF_TERMS_LOW = 5'h08;
  localparam logic [4:0] OFF_TERMS_HIGH = 5'h0C;
  localparam logic [4:0] OFF_DATA_LOW = 5'h10;
  localparam logic [4:0] OFF_DATA_HIGH = 5'h14;
  localparam logic [4:0] OFF_RESULT_LOW = 5'h18;
  localparam logic [4:0] OFF_RESULT_HIGH = 5'h1C;

  // ----------------------------------------------------------------
  // Field positions of the control and status register.
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE = 15;
  localparam int BIT_STOP_IDLE = 13;
  localparam int POS_COUNT = 8;
  localparam int BIT_FULL = 7;
  localparam int BIT_EMPTY = 6;
  localparam int BIT_IRQ_SEL = 5;
  localparam int BIT_GO = 4;
  localparam int BIT_DIR = 3;

  // ----------------------------------------------------------------
  // Field positions of the width configuration register.
  // ----------------------------------------------------------------
  localparam int POS_WIDTH = 8;
  localparam int POS_POLY_LENGTH_FIELD = 0;

  // ----------------------------------------------------------------
  // Reset values, depths and bus answers.
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [31:0] RST_REG32 = 32'h0000_0000;
  localparam logic [4:0] DEPTH_WIDE = 5'h04;
  localparam logic [4:0] DEPTH_MID = 5'h08;
  localparam logic [4:0] DEPTH_NARROW = 5'h10;
  localparam logic [4:0] WIDTH_MID_MIN = 5'h08;
  localparam logic [4:0] WIDTH_WIDE_MIN = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic enable;
    logic stopIdle;
    logic irqSel;
    logic lsbFirst;
  } pcrc_ctrl_s;

  typedef struct packed {
    logic [4:0] wordWidth;
    logic [4:0] polyLen;
  } pcrc_cfg_s;

endpackage

// ==== hw/pcrc_generator.sv ====
// Function
// - Length field holds polynomial order minus one.
// - Each set term bit adds an XOR tap.
// - Zero term always XORed; top term implicit.
// - Word width 1 to 32, field is width-1.
// - FIFO depth 4, 8 or 16 by width.
// - Byte is smallest write; upper bits ignored.
// - Count rises when word MSb byte written.
// - Shift only with go set and words waiting.
// - Load word to buffer, shift two bits/cycle.
// - Full at depth, empty at zero count.
// - Disabled module holds FIFO empty, count zero.
// - MSb first by default, LSb first when set.
// - Direction changes input order only.
// - Select 0 interrupts on count one to zero.
// - Select 1 interrupts on hardware go clear.
// - Result final (length+1)/2 cycles after interrupt.
// - Go bit clears itself when calculation completes.
// - Stop-in-idle halts module while idle; here only shifting, go and interrupt stop, FIFO pushes still occur.
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module pcrc_generator #(
  parameter int ADDR_W = 5
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic idleMode,
  output logic crcIrq,
  output logic resultReady,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  pcrc_pkg::pcrc_ctrl_s ctrl;
  pcrc_pkg::pcrc_cfg_s cfg;
  logic [15:0] termsLow;
  logic [15:0] termsHigh;
  logic [31:0] dataStage;
  logic [31:0] next_dataStage;
  logic [31:0] result;
  logic [31:0] fifoMem [16];
  logic [3:0] wrPtr;
  logic [3:0] rdPtr;
  logic [4:0] count;
  logic [4:0] depth;
  logic [4:0] settle;
  logic shiftGo;
  logic worked;
  logic [31:0] shBuf;
  logic [5:0] bitsLeft;
  logic lsbMode;
  logic [31:0] polyMask;
  logic [31:0] wordMask;
  logic [31:0] polyTaps;
  logic [4:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic awHeld;
  logic wHeld;
  logic doWrite;
  logic wrMapped;
  logic rdMapped;
  logic [4:0] arAddr;
  logic [15:0] wrLo16;
  logic [15:0] rdMux;
  logic running;
  logic push;
  logic pop;
  logic done;
  logic msbLane;
  logic wrCtrl;
  logic wrCfg;
  logic wrTermsLow;
  logic wrTermsHigh;
  logic wrDataLow;
  logic wrDataHigh;
  logic wrResultLow;
  logic wrResultHigh;
  logic [31:0] next_result;
  logic [31:0] next_shBuf;
  logic [5:0] next_bitsLeft;

  // ----------------------------------------------------------------
  // Bus write path.
  // ----------------------------------------------------------------
  // Address and data are latched independently so either may arrive
  // first; the write commits once both are held and no response waits.
  assign s_axi_awready = !awHeld;
  assign s_axi_wready = !wHeld;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign wrLo16 = wData[15:0];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awHeld <= 1'b0;
      awAddr <= 5'h00;
    end else if (s_axi_awvalid && !awHeld) begin
      awHeld <= 1'b1;
      awAddr <= {s_axi_awaddr[4:2], 2'b00};
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wHeld <= 1'b0;
      wData <= pcrc_pkg::RST_REG32;
      wStrb <= 4'h0;
    end else if (s_axi_wvalid && !wHeld) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  always_comb begin
    wrCtrl = 1'b0;
    wrCfg = 1'b0;
    wrTermsLow = 1'b0;
    wrTermsHigh = 1'b0;
    wrDataLow = 1'b0;
    wrDataHigh = 1'b0;
    wrResultLow = 1'b0;
    wrResultHigh = 1'b0;
    wrMapped = 1'b1;
    if (awAddr == pcrc_pkg::OFF_CONTROL) begin
      wrCtrl = doWrite;
    end else if (awAddr == pcrc_pkg::OFF_WIDTH_CFG) begin
      wrCfg = doWrite;
    end else if (awAddr == pcrc_pkg::OFF_TERMS_LOW) begin
      wrTermsLow = doWrite;
    end else if (awAddr == pcrc_pkg::OFF_TERMS_HIGH) begin
      wrTermsHigh = doWrite;
    end else if (awAddr == pcrc_pkg::OFF_DATA_LOW) begin
      wrDataLow = doWrite;
    end else if (awAddr == pcrc_pkg::OFF_DATA_HIGH) begin
      wrDataHigh = doWrite;
    end else if (awAddr == pcrc_pkg::OFF_RESULT_LOW) begin
      wrResultLow = doWrite;
    end else if (awAddr == pcrc_pkg::OFF_RESULT_HIGH) begin
      wrResultHigh = doWrite;
    end else begin
      wrMapped = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pcrc_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrMapped ? pcrc_pkg::RESP_OKAY
                              : pcrc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers.
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl <= '0;
    end else if (wrCtrl) begin
      if (wStrb[1]) begin
        ctrl.enable <= wData[pcrc_pkg::BIT_ENABLE];
        ctrl.stopIdle <= wData[pcrc_pkg::BIT_STOP_IDLE];
      end
      if (wStrb[0]) begin
        ctrl.irqSel <= wData[pcrc_pkg::BIT_IRQ_SEL];
        ctrl.lsbFirst <= wData[pcrc_pkg::BIT_DIR];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg <= '0;
    end else if (wrCfg) begin
      if (wStrb[1]) begin
        cfg.wordWidth <= wData[pcrc_pkg::POS_WIDTH +: 5];
      end
      if (wStrb[0]) begin
        cfg.polyLen <= wData[pcrc_pkg::POS_POLY_LENGTH_FIELD +: 5];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      termsLow <= pcrc_pkg::RST_REG16;
      termsHigh <= pcrc_pkg::RST_REG16;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (wrTermsLow && wStrb[b]) begin
          termsLow[b*8 +: 8] <= wrLo16[b*8 +: 8];
        end
        if (wrTermsHigh && wStrb[b]) begin
          termsHigh[b*8 +: 8] <= wrLo16[b*8 +: 8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-bit masks for polynomial order and word width.
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_mask
      assign polyMask[gi] = (5'(gi) <= cfg.polyLen);
      assign wordMask[gi] = (5'(gi) <= cfg.wordWidth);
    end
  endgenerate

  // The zero-order tap is forced; the top term is the feedback itself,
  // so even a 32nd-order polynomial needs no enable bit for it.
  assign polyTaps = {termsHigh, termsLow[15:1], 1'b1}
                    & polyMask;

  // ----------------------------------------------------------------
  // Input staging and FIFO.
  // ----------------------------------------------------------------
  always_comb begin
    next_dataStage = dataStage;
    for (int b = 0; b < 2; b++) begin
      if (wrDataLow && wStrb[b]) begin
        next_dataStage[b*8 +: 8] = wrLo16[b*8 +: 8];
      end
      if (wrDataHigh && wStrb[b]) begin
        next_dataStage[16 + b*8 +: 8] = wrLo16[b*8 +: 8];
      end
    end
  end

  // The high half must come last: the word is pushed from the staging
  // value as it stands when the lane holding its top bit is written.
  assign msbLane = cfg.wordWidth[4]
                   ? (wrDataHigh && wStrb[cfg.wordWidth[3]])
                   : (wrDataLow && wStrb[cfg.wordWidth[3]]);

  always_comb begin
    if (cfg.wordWidth >= pcrc_pkg::WIDTH_WIDE_MIN) begin
      depth = pcrc_pkg::DEPTH_WIDE;
    end else if (cfg.wordWidth >= pcrc_pkg::WIDTH_MID_MIN) begin
      depth = pcrc_pkg::DEPTH_MID;
    end else begin
      depth = pcrc_pkg::DEPTH_NARROW;
    end
  end

  assign running = ctrl.enable && !(ctrl.stopIdle && idleMode);
  assign push = ctrl.enable && msbLane && (count < depth);
  assign pop = running && shiftGo && (count != 5'h00)
               && (bitsLeft == 6'h00);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dataStage <= pcrc_pkg::RST_REG32;
    end else if (!ctrl.enable) begin
      dataStage <= pcrc_pkg::RST_REG32;
    end else begin
      dataStage <= next_dataStage;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      fifoMem[wrPtr] <= next_dataStage & wordMask;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrPtr <= 4'h0;
      rdPtr <= 4'h0;
      count <= 5'h00;
    end else if (!ctrl.enable) begin
      wrPtr <= 4'h0;
      rdPtr <= 4'h0;
      count <= 5'h00;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 4'h1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 4'h1;
      end
      count <= count + 5'(push) - 5'(pop);
    end
  end

  // ----------------------------------------------------------------
  // Shift engine.
  // ----------------------------------------------------------------
  function automatic logic [31:0] crcStep(input logic [31:0] c,
                                          input logic din,
                                          input logic [31:0] taps,
                                          input logic [31:0] mask,
                                          input logic [4:0] top);
    logic fb;
    fb = din ^ c[top];
    crcStep = ((c << 1) ^ (fb ? taps : 32'h0000_0000)) & mask;
  endfunction

  // MSb-first words are left-aligned at load so both orders shift out
  // of a fixed end; the remainder update itself is the same either way.
  always_comb begin
    next_result = result;
    next_shBuf = shBuf;
    next_bitsLeft = bitsLeft;
    if (pop) begin
      next_shBuf = ctrl.lsbFirst ? fifoMem[rdPtr]
                 : (fifoMem[rdPtr] << (5'h1F - cfg.wordWidth));
      next_bitsLeft = {1'b0, cfg.wordWidth} + 6'h01;
    end else if (running && bitsLeft != 6'h00) begin
      for (int k = 0; k < 2; k++) begin
        if (next_bitsLeft != 6'h00) begin
          next_result = crcStep(next_result,
                                lsbMode ? next_shBuf[0] : next_shBuf[31],
                                polyTaps, polyMask, cfg.polyLen);
          next_shBuf = lsbMode ? (next_shBuf >> 1) : (next_shBuf << 1);
          next_bitsLeft = next_bitsLeft - 6'h01;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shBuf <= pcrc_pkg::RST_REG32;
      bitsLeft <= 6'h00;
      lsbMode <= 1'b0;
    end else if (!ctrl.enable) begin
      shBuf <= pcrc_pkg::RST_REG32;
      bitsLeft <= 6'h00;
    end else begin
      shBuf <= next_shBuf;
      bitsLeft <= next_bitsLeft;
      if (pop) begin
        lsbMode <= ctrl.lsbFirst;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      result <= pcrc_pkg::RST_REG32;
    end else if (!ctrl.enable) begin
      result <= pcrc_pkg::RST_REG32;
    end else if (wrResultLow || wrResultHigh) begin
      for (int b = 0; b < 2; b++) begin
        if (wrResultLow && wStrb[b]) begin
          result[b*8 +: 8] <= wrLo16[b*8 +: 8];
        end
        if (wrResultHigh && wStrb[b]) begin
          result[16 + b*8 +: 8] <= wrLo16[b*8 +: 8];
        end
      end
    end else begin
      result <= next_result;
    end
  end

  // ----------------------------------------------------------------
  // Go bit, completion and interrupt.
  // ----------------------------------------------------------------
  assign done = shiftGo && worked && running && (count == 5'h00)
                && (bitsLeft == 6'h00);

  // A software write of go in the same cycle as completion wins.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shiftGo <= 1'b0;
      worked <= 1'b0;
    end else if (!ctrl.enable) begin
      shiftGo <= 1'b0;
      worked <= 1'b0;
    end else if (wrCtrl && wStrb[0]) begin
      shiftGo <= wData[pcrc_pkg::BIT_GO];
      worked <= worked && wData[pcrc_pkg::BIT_GO];
    end else if (done) begin
      shiftGo <= 1'b0;
      worked <= 1'b0;
    end else if (pop) begin
      worked <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      crcIrq <= 1'b0;
    end else if (ctrl.irqSel) begin
      crcIrq <= done && !(wrCtrl && wStrb[0]);
    end else begin
      crcIrq <= pop && !push && (count == 5'h01);
    end
  end

  // The remainder is counted as settling for (length+1)/2 cycles after
  // the interrupt, so software polling this flag sees a final value.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      settle <= 5'h00;
    end else if (!ctrl.enable) begin
      settle <= 5'h00;
    end else if (crcIrq) begin
      settle <= 5'((6'(cfg.polyLen) + 6'h01) >> 1);
    end else if (settle != 5'h00) begin
      settle <= settle - 5'h01;
    end
  end

  assign resultReady = !shiftGo && (bitsLeft == 6'h00) && !crcIrq
                       && (settle == 5'h00);

  // ----------------------------------------------------------------
  // Bus read path.
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign arAddr = {s_axi_araddr[4:2], 2'b00};

  always_comb begin
    rdMux = pcrc_pkg::RST_REG16;
    rdMapped = 1'b1;
    if (arAddr == pcrc_pkg::OFF_CONTROL) begin
      rdMux[pcrc_pkg::BIT_ENABLE] = ctrl.enable;
      rdMux[pcrc_pkg::BIT_STOP_IDLE] = ctrl.stopIdle;
      rdMux[pcrc_pkg::POS_COUNT +: 5] = count;
      rdMux[pcrc_pkg::BIT_FULL] = (count == depth);
      rdMux[pcrc_pkg::BIT_EMPTY] = (count == 5'h00);
      rdMux[pcrc_pkg::BIT_IRQ_SEL] = ctrl.irqSel;
      rdMux[pcrc_pkg::BIT_GO] = shiftGo;
      rdMux[pcrc_pkg::BIT_DIR] = ctrl.lsbFirst;
    end else if (arAddr == pcrc_pkg::OFF_WIDTH_CFG) begin
      rdMux[pcrc_pkg::POS_WIDTH +: 5] = cfg.wordWidth;
      rdMux[pcrc_pkg::POS_POLY_LENGTH_FIELD +: 5] = cfg.polyLen;
    end else if (arAddr == pcrc_pkg::OFF_TERMS_LOW) begin
      rdMux = {termsLow[15:1], 1'b0};
    end else if (arAddr == pcrc_pkg::OFF_TERMS_HIGH) begin
      rdMux = termsHigh;
    end else if (arAddr == pcrc_pkg::OFF_DATA_LOW) begin
      rdMux = dataStage[15:0];
    end else if (arAddr == pcrc_pkg::OFF_DATA_HIGH) begin
      rdMux = dataStage[31:16];
    end else if (arAddr == pcrc_pkg::OFF_RESULT_LOW) begin
      rdMux = result[15:0];
    end else if (arAddr == pcrc_pkg::OFF_RESULT_HIGH) begin
      rdMux = result[31:16];
    end else begin
      rdMapped = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= pcrc_pkg::RST_REG32;
      s_axi_rresp <= pcrc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rdMux};
      s_axi_rresp <= rdMapped ? pcrc_pkg::RESP_OKAY
                              : pcrc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== verification/pcrc_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module pcrc_checker #(
  parameter int ADDR_W = 5
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic idleMode,
  input wire logic crcIrq,
  input wire logic resultReady,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----
  // Bus handshakes.
  // ----
  sequence wrBoth;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Address and data are held for one cycle before the write commits,
  // so the answer comes two edges after a joint handshake.
  write_answer_a: assert property (
    (wrBoth ##0 !s_axi_bvalid) |=> ##1 s_axi_bvalid)
    else $error("write answer missing");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  read_answer_a: assert property (
    rdTaken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed early");
  // The low address bits are dropped, so an unaligned read is served as
  // the word that holds it.
  bad_addr_a: assert property (
    (rdTaken ##0 s_axi_araddr[1:0] != 2'h0)
      |=> s_axi_rresp == pcrc_pkg::RESP_OKAY)
    else $error("unaligned read not served as its word");
  upper_zero_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  // ----
  // Interrupt and completion.
  // ----
  irq_pulse_a: assert property (crcIrq |=> !crcIrq)
    else $error("interrupt longer than one cycle");
  settle_bound_a: assert property (crcIrq |-> ##[1:40] resultReady)
    else $error("result not final after interrupt");
endmodule
bind pcrc_generator pcrc_checker #(.ADDR_W(ADDR_W)) pcrc_checker_inst (.*);
`default_nettype wire

// ==== verification/pcrc_generator_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module pcrc_generator_tb;
  logic core_clk, rst, idleMode, crcIrq, resultReady;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdVal, lo, exp, taps, word;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, lastResp;
  logic [15:0] ctrl;
  logic [4:0] wl, pl;
  int miscompares, checks_done, dep, nw;
  int wls[6] = '{31, 16, 15, 8, 7, 0};
  pcrc_generator #(.ADDR_W(5)) pcrc_generator_inst (.*);
  always #5 core_clk = ~core_clk;
  // ----
  // Bus master, model and comparison.
  // ----
  task automatic wr(input logic [4:0] a, input logic [15:0] d,
                    input logic [3:0] s);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    lastResp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdVal = s_axi_rdata;
    lastResp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] seen,
                     input logic [31:0] ex);
    checks_done++;
    if (seen !== ex) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, ex, seen);
    end
  endtask
  task automatic push(input logic [4:0] w, input logic [31:0] v);
    wr(pcrc_pkg::OFF_DATA_LOW, v[15:0], 4'h3);
    if (w > 5'd15) wr(pcrc_pkg::OFF_DATA_HIGH, v[31:16], 4'h3);
  endtask
  function automatic logic [31:0] crc_model(logic [31:0] c, logic [31:0] v, int w, int p, logic [31:0] t, logic lsb);
    logic fb;
    logic [31:0] m;
    m = (p == 31) ? 32'hFFFFFFFF : ((32'h1 << (p + 1)) - 32'h1);
    for (int j = 0; j <= w; j++) begin
      fb = v[lsb ? j : w - j] ^ c[p];
      c = ((c << 1) ^ (fb ? (t | 32'h1) : 32'h0)) & m;
    end
    return c;
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----
  // Tests.
  // ----
  initial begin
    repeat (60000) @(posedge core_clk);
    miscompares++;
    summarize();
  end
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    {idleMode, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    miscompares = 0;
    checks_done = 0;
    void'($urandom(60));
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rd(pcrc_pkg::OFF_CONTROL);
    chk("control reset", rdVal, 32'h40);
    for (int a = 4; a < 32; a += 4) begin
      rd(5'(a));
      chk("register reset", rdVal, 32'h0);
    end
    // Unaligned accesses land on the word that holds them.
    rd(5'h02);
    chk("unaligned read resp", {30'h0, lastResp}, 32'h0);
    chk("unaligned read alias", rdVal, 32'h40);
    wr(5'h06, 16'hFFFF, 4'h3);
    chk("unaligned write resp", {30'h0, lastResp}, 32'h0);
    rd(pcrc_pkg::OFF_WIDTH_CFG);
    chk("unaligned write alias", rdVal, 32'h1F1F);
    foreach (wls[i]) begin
      wl = 5'(wls[i]);
      dep = (wl > 5'd15) ? 4 : (wl > 5'd7) ? 8 : 16;
      wr(pcrc_pkg::OFF_CONTROL, 16'h8000, 4'h3);
      wr(pcrc_pkg::OFF_WIDTH_CFG, {3'h0, wl, 8'h00}, 4'h3);
      wr(pcrc_pkg::OFF_DATA_LOW, 16'hFFFF, 4'h3);
      rd(pcrc_pkg::OFF_CONTROL);
      chk("count after low half", 32'(rdVal[12:8]), (wl > 5'd15) ? 0 : 1);
      if (wl > 5'd15) wr(pcrc_pkg::OFF_DATA_HIGH, 16'hFFFF, 4'h3);
      for (int n = 1; n <= dep; n++) push(wl, $urandom);
      rd(pcrc_pkg::OFF_CONTROL);
      chk("full status", rdVal, 32'h8080 | (dep << 8));
      wr(pcrc_pkg::OFF_CONTROL, 16'h0000, 4'h3);
      rd(pcrc_pkg::OFF_CONTROL);
      chk("disabled status", rdVal, 32'h40);
    end
    for (int i = 0; i < 10; i++) begin
      pl = (i == 0) ? 5'd15 : (i == 1) ? 5'd31 : 5'($urandom_range(31, 0));
      wl = 5'($urandom_range(31, 0));
      nw = $urandom_range(4, 1);
      taps = $urandom;
      ctrl = {1'b1, 1'b0, i == 2, 7'h00, 1'(i), 1'b0, 1'(i >> 1), 3'h0};
      wr(pcrc_pkg::OFF_CONTROL, ctrl, 4'h3);
      wr(pcrc_pkg::OFF_WIDTH_CFG, {3'h0, wl, 3'h0, pl}, 4'h3);
      wr(pcrc_pkg::OFF_TERMS_LOW, taps[15:0], 4'h3);
      wr(pcrc_pkg::OFF_TERMS_HIGH, taps[31:16], 4'h3);
      wr(pcrc_pkg::OFF_RESULT_LOW, 16'h0000, 4'h3);
      wr(pcrc_pkg::OFF_RESULT_HIGH, 16'h0000, 4'h3);
      exp = 32'h0;
      for (int n = 0; n < nw; n++) begin
        word = $urandom;
        push(wl, word);
        exp = crc_model(exp, word, wl, pl, taps, ctrl[3]);
      end
      idleMode <= (i == 2);
      wr(pcrc_pkg::OFF_CONTROL, ctrl | 16'h0010, 4'h3);
      if (i == 2) begin
        repeat (20) @(posedge core_clk);
        rd(pcrc_pkg::OFF_CONTROL);
        chk("count while idle", 32'(rdVal[12:8]), nw);
        idleMode <= 1'b0;
      end
      do @(posedge core_clk); while (crcIrq !== 1'b1);
      do @(posedge core_clk); while (resultReady !== 1'b1);
      rd(pcrc_pkg::OFF_RESULT_LOW);
      lo = rdVal;
      rd(pcrc_pkg::OFF_RESULT_HIGH);
      chk("remainder", {rdVal[15:0], lo[15:0]}, exp);
      rd(pcrc_pkg::OFF_CONTROL);
      chk("status after run", rdVal, {16'h0, ctrl} | 32'h40);
    end
    summarize();
  end
endmodule
`default_nettype wire
